// ==== design/flash_guard_consts.svh ====
`ifndef FLASH_GUARD_CONSTS_SVH
`define FLASH_GUARD_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ---------------------------------------------------------------
`define A_STATUS      8'h00
`define A_CONFIG      8'h04
`define A_GUARD_MODE  8'h08
`define A_PASS_LO     8'h0C
`define A_PASS_HI     8'h10
`define A_UNLOCK_LO   8'h14
`define A_UNLOCK_HI   8'h18
`define A_SECTOR      8'h1C
`define A_PPB_CMD     8'h20
`define A_DYB_ACCESS  8'h24
`define A_PPB_READ    8'h28
`define A_LOCK        8'h2C
`define A_ARRAY_OP    8'h30
`define A_OTP_PROG    8'h34
`define A_CFG_OTHER   8'h38
`define A_LEARN       8'h3C
`define A_PROT_READ   8'h40
`define A_ERR_CLEAR   8'h44

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ST_STATUS_WRITE_DISABLE       7
`define ST_PERR       6
`define ST_EERR       5
`define ST_RANGE_HI   4
`define ST_RANGE_LO   2
`define ST_WIP        0
`define CF_NV_HI      5
`define CF_NV_LO      2
`define CF_TB         5
`define CF_FREEZE     0
`define CMD_PROG      0
`define CMD_ERASE     1
`define CMD_LOCK_CLR  2
`define OTP_ADDR_W    11

// ---------------------------------------------------------------
// values and reset states
// ---------------------------------------------------------------
`define MODE_NONE     2'h3
`define MODE_PERSIST  2'h2
`define MODE_PASSWORD 2'h1
`define MODE_ILLEGAL  2'h0
`define DYB_PROTECT   8'h00
`define DYB_OPEN      8'hFF
`define PASS_RST      64'hFFFFFFFFFFFFFFFF
`define RANGE_ALL     3'h7

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS   25
`define CYC_PER_US      (1000 / `CLK_PERIOD_NS)
`define UNLOCK_DELAY_US 100
`define UNLOCK_DELAY_CYC (`UNLOCK_DELAY_US * `CYC_PER_US)
`define PROG_TIME_US    400
`define ERASE_TIME_US   2000

`endif

// ==== design/flash_guard_pkg.sv ====
package flash_guard_pkg;
	// operation sequencer states
	typedef enum {ST_IDLE, ST_OP, ST_PREPROG, ST_ERASE} op_state_t;
	// protection mode pair
	typedef logic [1:0] guard_mode_t;
endpackage

// ==== design/op_timer.sv ====
`timescale 1ns/10ps
`include "flash_guard_consts.svh"

module op_timer (
	input  wire logic        clk,     // device clock
	input  wire logic        nrst,    // sync reset, active low
	input  wire logic        start,   // load a new duration
	input  wire logic [15:0] dur_us,  // duration in microseconds
	output logic             done     // pulse at end of duration
);
	localparam int DIV = `CYC_PER_US;

	logic [7:0]  div_q;
	logic [15:0] cnt_q;
	logic        run_q;
	logic        tick;

	// microsecond enable divider
	assign tick = (div_q == 8'(DIV - 1));
	always_ff @(posedge clk)
	begin
		if (!nrst || start || tick)
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
	end

	// countdown of microsecond ticks
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			cnt_q <= 16'h0000;
			run_q <= 1'b0;
			done  <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				cnt_q <= dur_us;
				run_q <= 1'b1;
			end
			else if (run_q && tick)
			begin
				cnt_q <= cnt_q - 16'h0001;
				if (cnt_q <= 16'h0001)
				begin
					run_q <= 1'b0;
					done  <= 1'b1;
				end
			end
		end
	end
endmodule

// ==== design/flash_guard.sv ====
// Our own choices: the strobed register port and the address map.
`timescale 1ns/10ps
`include "flash_guard_consts.svh"

module flash_guard
	import flash_guard_pkg::*;
#(
	parameter int          NUM_SECTORS   = 256,            // main array sectors
	parameter logic [15:0] PROG_TIME_US  = `PROG_TIME_US,  // page program time
	parameter logic [15:0] ERASE_TIME_US = `ERASE_TIME_US  // sector erase time
)(
	input  wire logic        clk,            // 40 MHz device clock
	input  wire logic        nrst,           // power-on reset, active low
	input  wire logic        wp_n_pin,       // write-protect pin, active low
	input  wire logic        hw_reset_n_pin, // hardware reset pin, active low
	input  wire logic [7:0]  addr,           // register address
	input  wire logic [31:0] wdata,          // write data
	input  wire logic        wr,             // write strobe
	input  wire logic        rd,             // read strobe
	output logic      [31:0] rdata,          // read data, cycle after rd
	output logic             write_in_progress             // write in progress
);
	import flash_guard_pkg::*;

	localparam int SEC_W = $clog2(NUM_SECTORS);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [1:0]       wp_s_q, hwr_s_q;
	logic             status_write_disable_q, p_err_q, e_err_q, freeze_q, lock_q;
	logic [2:0]       range_q;
	logic [3:0]       cfgnv_q;
	guard_mode_t      mode_q;
	logic [63:0]      pass_q;
	logic [31:0]      unlock_lo_q;
	logic [23:0]      other_q;
	logic [7:0]       learn_q;
	logic [SEC_W-1:0] sec_q;
	logic [NUM_SECTORS-1:0] ppb_q, dyb_q, prot_vec;
	op_state_t        state_q;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			wp_s_q  <= 2'h3;
			hwr_s_q <= 2'h3;
		end
		else
		begin
			wp_s_q  <= {wp_s_q[0], wp_n_pin};
			hwr_s_q <= {hwr_s_q[0], hw_reset_n_pin};
		end
	end

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	logic hw_rst, idle, wp_lock, mode_set, pw_mode, match, otp_valid;
	logic go_arr, go_ppb, go_mode, go_pass, go_unlock, go_otp, go_other;
	logic cfg_wr, st_wr, perr_set, eerr_set, start_op, start_pre;
	logic arr_ok, ppbp_ok, ppbe_ok, mode_ok, pass_ok, otp_ok, other_ok;
	logic [1:0]  new_mode;
	logic [15:0] op_dur, tmr_dur;
	logic        tmr_start, tmr_done;

	assign hw_rst    = !hwr_s_q[1];
	assign idle      = (state_q == ST_IDLE) && !hw_rst;
	assign wp_lock   = !wp_s_q[1] && status_write_disable_q;
	assign mode_set  = (mode_q != `MODE_NONE);
	assign pw_mode   = (mode_q == `MODE_PASSWORD);
	assign new_mode  = mode_q & wdata[2:1];
	assign match     = ({wdata, unlock_lo_q} == pass_q);
	assign otp_valid = (wdata[31:`OTP_ADDR_W] == '0);
	assign st_wr     = wr && addr == `A_STATUS && !wp_lock && !hw_rst;
	assign cfg_wr    = wr && addr == `A_CONFIG && !wp_lock && !hw_rst;
	assign go_arr    = wr && addr == `A_ARRAY_OP && idle;
	assign go_ppb    = wr && addr == `A_PPB_CMD && idle;
	assign go_mode   = wr && addr == `A_GUARD_MODE && idle;
	assign go_pass   = wr && (addr == `A_PASS_LO || addr == `A_PASS_HI) && idle;
	assign go_unlock = wr && addr == `A_UNLOCK_HI && idle && pw_mode;
	assign go_otp    = wr && addr == `A_OTP_PROG && idle && otp_valid;
	assign go_other  = wr && (addr == `A_CFG_OTHER || addr == `A_LEARN) && idle;

	assign arr_ok   = go_arr && (wdata[`CMD_PROG] || wdata[`CMD_ERASE]) && !prot_vec[sec_q];
	assign ppbp_ok  = go_ppb && wdata[`CMD_PROG] && lock_q;
	assign ppbe_ok  = go_ppb && wdata[`CMD_ERASE] && lock_q;
	assign mode_ok  = go_mode && !mode_set && new_mode != `MODE_ILLEGAL;
	assign pass_ok  = go_pass && !mode_set;
	assign otp_ok   = go_otp && !freeze_q;
	assign other_ok = go_other && !mode_set;

	// refused commands raise the error flags; out-of-range OTP addresses and commands while busy are dropped
	assign perr_set = (go_arr && wdata[`CMD_PROG] && prot_vec[sec_q])
		|| (go_ppb && wdata[`CMD_PROG] && !lock_q)
		|| (go_mode && !mode_ok)
		|| (go_pass && mode_set) || (go_other && mode_set)
		|| (cfg_wr && mode_set && wdata[`CF_NV_HI:`CF_NV_LO] != cfgnv_q)
		|| (go_unlock && !match)
		|| (go_otp && freeze_q);
	assign eerr_set = (go_arr && wdata[`CMD_ERASE] && prot_vec[sec_q])
		|| (go_ppb && wdata[`CMD_ERASE] && !lock_q);

	assign start_pre = ppbe_ok && !wdata[`CMD_PROG];
	assign start_op  = (arr_ok || ppbp_ok || mode_ok || pass_ok || otp_ok || other_ok
		|| (go_unlock && !match)) && !start_pre;
	assign op_dur    = (go_unlock) ? 16'(`UNLOCK_DELAY_US) :
		(go_arr && wdata[`CMD_ERASE]) ? ERASE_TIME_US : PROG_TIME_US;
	assign tmr_start = start_op || start_pre || (state_q == ST_PREPROG && tmr_done);
	assign tmr_dur   = (state_q == ST_PREPROG) ? ERASE_TIME_US : op_dur;

	// ---------------------------------------------------------------
	// protection map: one entry per sector
	// ---------------------------------------------------------------
	logic [SEC_W:0] range_cnt;
	assign range_cnt = (range_q == 3'h0) ? '0 :
		(SEC_W+1)'(NUM_SECTORS >> (`RANGE_ALL - range_q));
	for (genvar i = 0; i < NUM_SECTORS; i++)
	begin : g_prot
		logic in_range;
		assign in_range = cfgnv_q[`CF_TB - `CF_NV_LO]
			? ((SEC_W+1)'(i) < range_cnt)
			: ((SEC_W+1)'(i) >= (SEC_W+1)'(NUM_SECTORS) - range_cnt);
		assign prot_vec[i] = in_range || !ppb_q[i] || !dyb_q[i];
	end

	// ---------------------------------------------------------------
	// status one: write disable and range bits
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			status_write_disable_q  <= 1'b0;
			range_q <= 3'h0;
		end
		else if (st_wr)
		begin
			status_write_disable_q <= wdata[`ST_STATUS_WRITE_DISABLE];
			if (!freeze_q)
				range_q <= wdata[`ST_RANGE_HI:`ST_RANGE_LO];
		end
	end

	// ---------------------------------------------------------------
	// config one: one-time bits and freeze
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			cfgnv_q  <= 4'h0;
			freeze_q <= 1'b0;
		end
		else if (cfg_wr)
		begin
			if (!mode_set && !freeze_q)
				cfgnv_q <= wdata[`CF_NV_HI:`CF_NV_LO];
			if (wdata[`CF_FREEZE])
				freeze_q <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// one-time registers: mode, password, other config, pattern
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			mode_q  <= `MODE_NONE;
			pass_q  <= `PASS_RST;
			other_q <= 24'h000000;
			learn_q <= 8'h00;
		end
		else
		begin
			if (mode_ok)
				mode_q <= new_mode;
			if (pass_ok && addr == `A_PASS_LO)
				pass_q[31:0] <= pass_q[31:0] & wdata;
			if (pass_ok && addr == `A_PASS_HI)
				pass_q[63:32] <= pass_q[63:32] & wdata;
			if (other_ok && addr == `A_CFG_OTHER)
				other_q <= wdata[23:0];
			if (other_ok && addr == `A_LEARN)
				learn_q <= wdata[7:0];
		end
	end

	// ---------------------------------------------------------------
	// error flags: a set in the clearing cycle wins
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst || hw_rst)
		begin
			p_err_q <= 1'b0;
			e_err_q <= 1'b0;
		end
		else
		begin
			if (perr_set)
				p_err_q <= 1'b1;
			else if (wr && addr == `A_ERR_CLEAR)
				p_err_q <= 1'b0;
			if (eerr_set)
				e_err_q <= 1'b1;
			else if (wr && addr == `A_ERR_CLEAR)
				e_err_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// persistent-bit lock
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
			lock_q <= 1'b1;
		else if (hw_rst)
			lock_q <= !pw_mode;
		else if (wr && addr == `A_PPB_CMD && wdata[`CMD_LOCK_CLR])
			lock_q <= 1'b0;
		else if (go_unlock && match)
			lock_q <= 1'b1;
	end

	// ---------------------------------------------------------------
	// sector address, persistent and dynamic bits
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
			sec_q <= '0;
		else if (wr && addr == `A_SECTOR)
			sec_q <= wdata[SEC_W-1:0];
	end

	// low half of an unlock attempt, compared when the high half arrives
	always_ff @(posedge clk)
	begin
		if (!nrst)
			unlock_lo_q <= 32'h00000000;
		else if (wr && addr == `A_UNLOCK_LO)
			unlock_lo_q <= wdata;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			ppb_q <= '1;
		else if (ppbp_ok)
			ppb_q[sec_q] <= 1'b0;
		else if (state_q == ST_PREPROG && tmr_done)
			ppb_q <= '0;
		else if (state_q == ST_ERASE && tmr_done)
			ppb_q <= '1;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst || hw_rst)
			dyb_q <= '1;
		else if (wr && addr == `A_DYB_ACCESS && wdata[7:0] == `DYB_PROTECT)
			dyb_q[sec_q] <= 1'b0;
		else if (wr && addr == `A_DYB_ACCESS && wdata[7:0] == `DYB_OPEN)
			dyb_q[sec_q] <= 1'b1;
	end

	// ---------------------------------------------------------------
	// operation sequencer and busy flag
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst || hw_rst)
			state_q <= ST_IDLE;
		else
			case (state_q)
				ST_IDLE:
					if (start_pre)
						state_q <= ST_PREPROG;
					else if (start_op)
						state_q <= ST_OP;
				ST_OP:
					if (tmr_done)
						state_q <= ST_IDLE;
				ST_PREPROG:
					if (tmr_done)
						state_q <= ST_ERASE;
				ST_ERASE:
					if (tmr_done)
						state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (!nrst || hw_rst)
			write_in_progress <= 1'b0;
		else
			// busy stays up across the handover from preprogram to erase
			write_in_progress <= (state_q == ST_PREPROG) || (state_q != ST_IDLE && !tmr_done)
				|| start_op || start_pre;
	end

	op_timer u_timer (
		.clk    (clk),
		.nrst   (nrst),
		.start  (tmr_start),
		.dur_us (tmr_dur),
		.done   (tmr_done)
	);

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst || !rd)
			rdata <= 32'h00000000;
		else
			case (addr)
				`A_STATUS:     rdata <= {24'h0, status_write_disable_q, p_err_q, e_err_q, range_q, 1'b0, write_in_progress};
				`A_CONFIG:     rdata <= {26'h0, cfgnv_q, 1'b0, freeze_q};
				`A_GUARD_MODE: rdata <= {29'h0, mode_q, 1'b1};
				`A_PASS_LO:    rdata <= pw_mode ? 32'hFFFFFFFF : pass_q[31:0];
				`A_PASS_HI:    rdata <= pw_mode ? 32'hFFFFFFFF : pass_q[63:32];
				`A_SECTOR:     rdata <= 32'(sec_q);
				`A_DYB_ACCESS: rdata <= dyb_q[sec_q] ? 32'h000000FF : 32'h00000000;
				`A_PPB_READ:   rdata <= ppb_q[sec_q] ? 32'h000000FF : 32'h00000000;
				`A_LOCK:       rdata <= {31'h0, lock_q};
				`A_CFG_OTHER:  rdata <= {8'h0, other_q};
				`A_LEARN:      rdata <= {24'h0, learn_q};
				`A_PROT_READ:  rdata <= {31'h0, prot_vec[sec_q]};
				default:       rdata <= 32'h00000000;
			endcase
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_range_all_prot:
		assert property (range_q == `RANGE_ALL |-> &prot_vec)
		else $error("full range does not protect every sector");
	a_bottom_first:
		assert property (range_q != 3'h0 && cfgnv_q[3] |-> prot_vec[0])
		else $error("bottom range leaves sector zero open");
	a_wp_status_hold:
		assert property (wr && addr == `A_STATUS && wp_lock |=> $stable(range_q) && $stable(status_write_disable_q))
		else $error("status changed under write protect");
	a_freeze_range:
		assert property (wr && addr == `A_STATUS && freeze_q |=> $stable(range_q))
		else $error("range bits changed while frozen");
	a_ppb_locked:
		assert property (go_ppb && wdata[`CMD_PROG] && !lock_q |=> p_err_q && $stable(ppb_q))
		else $error("locked persistent program not refused");
	a_lock_no_set:
		assert property (!pw_mode && !lock_q && !hw_rst |=> !lock_q)
		else $error("persistent lock rose without reset");
	a_unlock_fail:
		assert property (go_unlock && !match |=> p_err_q && write_in_progress && !lock_q ##1 write_in_progress[*8])
		else $error("unlock mismatch not handled");
	a_mode_illegal:
		assert property (go_mode && new_mode == `MODE_ILLEGAL |=> p_err_q && $stable(mode_q))
		else $error("illegal mode pair accepted");
	a_dyb_clear:
		assert property (wr && addr == `A_DYB_ACCESS && wdata[7:0] == `DYB_PROTECT && !hw_rst
			|=> prot_vec[$past(sec_q)])
		else $error("dynamic clear left sector open");
	a_array_reject:
		assert property (go_arr && wdata[`CMD_ERASE] && prot_vec[sec_q] |=> e_err_q && !write_in_progress)
		else $error("erase of protected sector not refused");
endmodule

// ==== testbench/host_model.sv ====
`timescale 1ns/10ps
`include "flash_guard_consts.svh"

// ---------------------------------------------------------------
// host controller: register bus master
// ---------------------------------------------------------------
module host_model (
	input  wire logic        clk,   // device clock
	input  wire logic [31:0] rdata, // read data
	output logic      [7:0]  addr,  // register address
	output logic      [31:0] wdata, // write data
	output logic             wr,    // write strobe
	output logic             rd     // read strobe
);
	// bus idle at time zero
	initial
	begin
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
	end

	// one-cycle write; data line scrambled once released
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask

	// one-cycle read; data taken in the following cycle
	task automatic r(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// poll the status word until the busy bit drops
	task automatic wait_idle();
		logic [31:0] s;
		s = 32'h1;
		for (int i = 0; i < 3000 && s[`ST_WIP] === 1'b1; i++)
			r(`A_STATUS, s);
	endtask
endmodule

// ==== testbench/flash_guard_bench.sv ====
`timescale 1ns/10ps
`include "flash_guard_consts.svh"

// ---------------------------------------------------------------
// self-checking bench
// ---------------------------------------------------------------
module flash_guard_bench;
	import flash_guard_pkg::*;
	localparam int NS = 256;
	localparam logic [63:0] PW = 64'h0123456789ABCDEF;
	logic        clk, nrst, wp_n_pin, hw_reset_n_pin, wr, rd, write_in_progress;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	int          num_errors, compares, cycles, n, tb, cnt;

	flash_guard #(.NUM_SECTORS(NS), .PROG_TIME_US(16'h2), .ERASE_TIME_US(16'h3)) i_dut (
		.clk(clk), .nrst(nrst), .wp_n_pin(wp_n_pin), .hw_reset_n_pin(hw_reset_n_pin),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .write_in_progress(write_in_progress));
	host_model i_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

	// clock and hang guard
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		i_host.r(a, d);
		check(d, e);
	endtask
	task automatic pc(input int s, input logic e);
		i_host.w(`A_SECTOR, 32'(s));
		rc(`A_PROT_READ, {31'h0, e});
	endtask
	task automatic hw_pulse();
		@(posedge clk);
		hw_reset_n_pin <= 1'b0;
		repeat (4) @(posedge clk);
		hw_reset_n_pin <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	// count cycles of busy after a command
	task automatic busy_len(output int c);
		c = 0;
		for (int i = 0; i < 9000 && (write_in_progress === 1'b1 || i < 4); i++)
		begin
			@(posedge clk);
			#1;
			if (write_in_progress === 1'b1)
				c++;
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d, compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		nrst = 1'b0;
		wp_n_pin = 1'b1;
		hw_reset_n_pin = 1'b1;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		rc(`A_STATUS, 32'h0);
		rc(`A_GUARD_MODE, 32'h7);
		rc(`A_LOCK, 32'h1);
		rc(`A_PPB_READ, 32'hFF);
		rc(`A_DYB_ACCESS, 32'hFF);
		// range sizes at both anchors
		for (tb = 0; tb < 2; tb++)
		begin
			i_host.w(`A_CONFIG, 32'(tb << 5));
			for (n = 0; n < 8; n++)
			begin
				cnt = (n == 0) ? 0 : (NS >> (7 - n));
				i_host.w(`A_STATUS, 32'(n << 2));
				if (cnt > 0)
					pc(tb ? cnt - 1 : NS - cnt, 1'b1);
				if (cnt < NS)
					pc(tb ? cnt : NS - cnt - 1, 1'b0);
			end
		end
		i_host.w(`A_STATUS, 32'h0);
		// dynamic bit and refused array operations
		i_host.w(`A_SECTOR, 32'h5);
		i_host.w(`A_DYB_ACCESS, 32'(`DYB_PROTECT));
		rc(`A_DYB_ACCESS, 32'h0);
		rc(`A_PROT_READ, 32'h1);
		i_host.w(`A_ARRAY_OP, 32'h1);
		rc(`A_STATUS, 32'h40);
		i_host.w(`A_ERR_CLEAR, 32'h0);
		i_host.w(`A_ARRAY_OP, 32'h2);
		rc(`A_STATUS, 32'h20);
		i_host.w(`A_ERR_CLEAR, 32'h0);
		i_host.w(`A_DYB_ACCESS, 32'(`DYB_OPEN));
		rc(`A_PROT_READ, 32'h0);
		// persistent bits: program one, erase all
		i_host.w(`A_SECTOR, 32'h7);
		i_host.w(`A_PPB_CMD, 32'h1);
		i_host.wait_idle();
		rc(`A_PPB_READ, 32'h0);
		rc(`A_PROT_READ, 32'h1);
		pc(8, 1'b0);
		i_host.w(`A_PPB_CMD, 32'h2);
		busy_len(cnt);
		check({31'h0, cnt >= 200 && cnt < 400}, 32'h1);
		i_host.w(`A_SECTOR, 32'h7);
		rc(`A_PPB_READ, 32'hFF);
		// lock cleared: persistent bits frozen
		i_host.w(`A_SECTOR, 32'h9);
		i_host.w(`A_PPB_CMD, 32'h1);
		i_host.wait_idle();
		i_host.w(`A_PPB_CMD, 32'h4);
		rc(`A_LOCK, 32'h0);
		i_host.w(`A_PPB_CMD, 32'h2);
		i_host.wait_idle();
		rc(`A_PPB_READ, 32'h0);
		i_host.w(`A_SECTOR, 32'hA);
		i_host.w(`A_PPB_CMD, 32'h1);
		i_host.wait_idle();
		rc(`A_PPB_READ, 32'hFF);
		hw_pulse();
		rc(`A_LOCK, 32'h1);
		// write-protect pin with write-disable set
		i_host.w(`A_STATUS, 32'h80);
		wp_n_pin <= 1'b0;
		repeat (4) @(posedge clk);
		i_host.w(`A_STATUS, 32'h9C);
		rc(`A_STATUS, 32'h80);
		i_host.w(`A_CONFIG, 32'h21);
		rc(`A_CONFIG, 32'h20);
		wp_n_pin <= 1'b1;
		repeat (4) @(posedge clk);
		i_host.w(`A_STATUS, 32'h0);
		rc(`A_STATUS, 32'h0);
		// freeze locks range bits and OTP
		i_host.w(`A_CONFIG, 32'h21);
		rc(`A_CONFIG, 32'h21);
		i_host.w(`A_STATUS, 32'h4);
		rc(`A_STATUS, 32'h0);
		i_host.w(`A_OTP_PROG, 32'h5);
		i_host.wait_idle();
		rc(`A_STATUS, 32'h40);
		i_host.w(`A_ERR_CLEAR, 32'h0);
		i_host.w(`A_OTP_PROG, 32'h800);
		i_host.wait_idle();
		rc(`A_STATUS, 32'h0);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		rc(`A_CONFIG, 32'h0);
		// password first, then mode selection
		i_host.w(`A_PASS_LO, PW[31:0]);
		i_host.wait_idle();
		i_host.w(`A_PASS_HI, PW[63:32]);
		i_host.wait_idle();
		i_host.w(`A_GUARD_MODE, 32'h0);
		i_host.wait_idle();
		rc(`A_STATUS, 32'h40);
		rc(`A_GUARD_MODE, 32'h7);
		i_host.w(`A_ERR_CLEAR, 32'h0);
		i_host.w(`A_GUARD_MODE, 32'h2);
		@(posedge clk);
		#1;
		check({31'h0, write_in_progress}, 32'h1);
		i_host.wait_idle();
		rc(`A_GUARD_MODE, 32'h3);
		i_host.w(`A_CONFIG, 32'h4);
		rc(`A_STATUS, 32'h40);
		rc(`A_CONFIG, 32'h0);
		i_host.w(`A_ERR_CLEAR, 32'h0);
		i_host.w(`A_LEARN, 32'h5A);
		i_host.wait_idle();
		rc(`A_STATUS, 32'h40);
		i_host.w(`A_ERR_CLEAR, 32'h0);
		hw_pulse();
		rc(`A_LOCK, 32'h0);
		i_host.w(`A_UNLOCK_LO, PW[31:0]);
		i_host.w(`A_UNLOCK_HI, ~PW[63:32]);
		busy_len(cnt);
		check({31'h0, cnt >= 3200 && cnt <= 4800}, 32'h1);
		rc(`A_STATUS, 32'h40);
		rc(`A_LOCK, 32'h0);
		i_host.w(`A_ERR_CLEAR, 32'h0);
		i_host.w(`A_UNLOCK_LO, PW[31:0]);
		i_host.w(`A_UNLOCK_HI, PW[63:32]);
		busy_len(cnt);
		check({31'h0, cnt < 40}, 32'h1);
		rc(`A_LOCK, 32'h1);
		// persistent mode chosen for good: lock returns at hardware reset
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		i_host.w(`A_GUARD_MODE, 32'h4);
		i_host.wait_idle();
		rc(`A_GUARD_MODE, 32'h5);
		i_host.w(`A_PPB_CMD, 32'h4);
		rc(`A_LOCK, 32'h0);
		hw_pulse();
		rc(`A_LOCK, 32'h1);
		wrap_up();
	end
endmodule
